// >>> common/strobe_ctrl_pkg.sv
// Purpose: Shared constants and types for the camera output line strobe control.
// Assumes: 50 MHz system clock; times counted in one-microsecond ticks.
// Notes:   Every offset-free setting of the block is a plain port.
package strobe_ctrl_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CLK_FREQ_HZ     = 50000000;
   localparam int unsigned TICK_TIME_NS    = 1000;
   localparam int unsigned CLK_PERIOD_NS   = 1000000000 / CLK_FREQ_HZ;
   localparam int unsigned TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned MAX_TIME_US     = 5000000;
   localparam int unsigned TIME_W          = 23;
   localparam int unsigned TICK_W          = 6;

   // ***************************************************************
   // Line layout
   // ***************************************************************
   localparam int unsigned NUM_LINES       = 3;
   localparam int unsigned LINE_ISO        = 0;
   localparam int unsigned LINE_GEN_A      = 1;
   localparam int unsigned LINE_GEN_B      = 2;
   localparam logic [2:0]  LINES_RESET     = 3'h0;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic {SRC_STROBE = 1'b0, SRC_USER = 1'b1} out_src_t;
   typedef enum logic {MODE_PRE_DELAY = 1'b0, MODE_DELAY = 1'b1} delay_mode_t;

   typedef struct packed {
      delay_mode_t        delay_mode;
      logic [TIME_W-1:0]  delay_us;
      logic [TIME_W-1:0]  high_us;
   } strobe_cfg_t;

   typedef struct packed {
      out_src_t  src;
      logic      invert;
      logic      is_output;
   } line_cfg_t;

endpackage : strobe_ctrl_pkg

// >>> design/us_tick_gen.sv
// Purpose: One-microsecond tick generator.
// Assumes: Clock rate given by the package.
// Notes:   The tick is a one-cycle pulse every TICK_CYCLES clocks.
`timescale 1ns/100ps
module us_tick_gen #(
   parameter int unsigned CYCLES = strobe_ctrl_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // Restart and tick
   input  wire logic restart,
   output logic      tick
);
   logic [strobe_ctrl_pkg::TICK_W-1:0] cnt_reg;
   logic [strobe_ctrl_pkg::TICK_W-1:0] cnt_next;

   always_comb
   begin
      if (restart || cnt_reg == strobe_ctrl_pkg::TICK_W'(CYCLES - 1))
         cnt_next = '0;
      else
         cnt_next = cnt_reg + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign tick = !restart && cnt_reg == strobe_ctrl_pkg::TICK_W'(CYCLES - 1);

endmodule : us_tick_gen

// >>> design/camera_output_line_strobe_ctrl.sv
// Purpose: Drives the isolated output and two general lines from strobe or user value.
// Assumes: exposure_start and exposure_end are pulses from logic on sys_clk.
// Notes:   Pre-delay counts from exposure start, delay counts from exposure end.
`timescale 1ns/100ps
// Overview of operation
// R1: Strobe source uses delay mode, time, duration.
// R2: User source drives line from user value.
// R3: Bit2 general_line_b, bit1 general_line_a, bit0 isolated.
// R4: Inversion only on isolated or output lines.
// R5: Delay mode is pre-delay or delay.
// R6: Strobe postponed by delay time after reference.
// R7: Strobe held high for programmed duration.
// R8: Only lower three user bits used.
// R9: Delay counted in microsecond ticks from reference.
module camera_output_line_strobe_ctrl #(
   parameter int unsigned TICK_CYCLES = strobe_ctrl_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                            sys_clk,
   input  wire logic                            arst_n,
   // Exposure events
   input  wire logic                            exposure_start,
   input  wire logic                            exposure_end,
   // Settings
   input  wire strobe_ctrl_pkg::strobe_cfg_t    strobe_cfg,
   input  wire strobe_ctrl_pkg::line_cfg_t [2:0] line_cfg,
   input  wire logic [31:0]                     user_output_value,
   // Status and lines
   output logic                                 strobe_active,
   output logic [2:0]                           line_out
);

   // ***************************************************************
   // Strobe sequencer
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_HIGH  = 3'b100
   } strobe_state_t;

   strobe_state_t                       state_reg;
   strobe_state_t                       state_next;
   logic [strobe_ctrl_pkg::TIME_W-1:0]  count_reg;
   logic [strobe_ctrl_pkg::TIME_W-1:0]  count_next;
   logic                                ref_event;
   logic                                tick;
   logic                                restart;
   logic [strobe_ctrl_pkg::TIME_W-1:0]  delay_sat;
   logic [strobe_ctrl_pkg::TIME_W-1:0]  high_sat;

   localparam logic [strobe_ctrl_pkg::TIME_W-1:0] TIME_MAX =
      strobe_ctrl_pkg::TIME_W'(strobe_ctrl_pkg::MAX_TIME_US);

   // Settings above the maximum saturate rather than wrap, so a bad write is still bounded.
   assign delay_sat = (strobe_cfg.delay_us > TIME_MAX) ? TIME_MAX : strobe_cfg.delay_us;
   assign high_sat  = (strobe_cfg.high_us > TIME_MAX) ? TIME_MAX : strobe_cfg.high_us;

   // Pre-delay references exposure start, delay references exposure end.
   assign ref_event = (strobe_cfg.delay_mode == strobe_ctrl_pkg::MODE_PRE_DELAY)
                      ? exposure_start : exposure_end; // R5

   assign restart = ref_event && state_reg == ST_IDLE;

   us_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .restart (restart),
      .tick    (tick)
   ); // R9

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (ref_event)
            begin
               count_next = '0;
               if (delay_sat != '0)
                  state_next = ST_DELAY; // R6
               else if (high_sat != '0)
                  state_next = ST_HIGH;
            end
         end
         ST_DELAY:
         begin
            if (tick)
            begin
               if (count_reg + 1'b1 >= delay_sat)
               begin
                  count_next = '0;
                  state_next = (high_sat != '0) ? ST_HIGH : ST_IDLE; // R6
               end
               else
                  count_next = count_reg + 1'b1; // R9
            end
         end
         ST_HIGH:
         begin
            if (tick)
            begin
               if (count_reg + 1'b1 >= high_sat)
               begin
                  count_next = '0;
                  state_next = ST_IDLE; // R7
               end
               else
                  count_next = count_reg + 1'b1; // R7
            end
         end
         default:
         begin
            state_next = ST_IDLE;
            count_next = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_IDLE;
         count_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   assign strobe_active = (state_reg == ST_HIGH);

   // ***************************************************************
   // Line output selection
   // ***************************************************************
   logic [2:0] lines_reg;
   logic [2:0] lines_next;
   logic [2:0] user_bits;

   // Upper bits of the written value are simply not wired.
   assign user_bits = user_output_value[2:0]; // R8

   always_comb
   begin
      for (int i = 0; i < strobe_ctrl_pkg::NUM_LINES; i++)
      begin
         logic lvl;
         logic inv_ok;
         lvl    = (line_cfg[i].src == strobe_ctrl_pkg::SRC_USER)
                  ? user_bits[i]        // R2 R3
                  : strobe_active;      // R1
         inv_ok = (i == strobe_ctrl_pkg::LINE_ISO) || line_cfg[i].is_output; // R4
         lines_next[i] = lvl ^ (line_cfg[i].invert & inv_ok); // R4
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         lines_reg <= strobe_ctrl_pkg::LINES_RESET;
      else
         lines_reg <= lines_next;
   end

   assign line_out = lines_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_user_map;
      @(posedge sys_clk) disable iff (!arst_n)
      (line_cfg[strobe_ctrl_pkg::LINE_GEN_B].src == strobe_ctrl_pkg::SRC_USER
       && !line_cfg[strobe_ctrl_pkg::LINE_GEN_B].invert)
      |=> line_out[strobe_ctrl_pkg::LINE_GEN_B] == $past(user_output_value[2]);
   endproperty
   a_user_map: assert property (p_user_map) else $error("user bit 2 not on line b"); // R3

   property p_user_iso;
      @(posedge sys_clk) disable iff (!arst_n)
      (line_cfg[0].src == strobe_ctrl_pkg::SRC_USER)
      |=> line_out[0] == $past(user_output_value[0] ^ line_cfg[0].invert);
   endproperty
   a_user_iso: assert property (p_user_iso) else $error("isolated line wrong in user mode"); // R2

   property p_inv_blocked;
      @(posedge sys_clk) disable iff (!arst_n)
      (line_cfg[1].src == strobe_ctrl_pkg::SRC_USER && !line_cfg[1].is_output)
      |=> line_out[1] == $past(user_output_value[1]);
   endproperty
   a_inv_blocked: assert property (p_inv_blocked) else $error("input line inverted"); // R4

   property p_no_immediate;
      @(posedge sys_clk) disable iff (!arst_n)
      (state_reg == ST_IDLE && ref_event && delay_sat != '0) |=> !strobe_active [*2];
   endproperty
   a_no_immediate: assert property (p_no_immediate) else $error("strobe not delayed"); // R6

   property p_zero_delay;
      @(posedge sys_clk) disable iff (!arst_n)
      (state_reg == ST_IDLE && ref_event && delay_sat == '0 && high_sat != '0)
      |=> strobe_active;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay strobe late"); // R6

   property p_high_ends;
      @(posedge sys_clk) disable iff (!arst_n)
      (strobe_active && tick && count_reg + 1'b1 >= high_sat) |=> !strobe_active;
   endproperty
   a_high_ends: assert property (p_high_ends) else $error("strobe high too long"); // R7

   property p_high_holds;
      @(posedge sys_clk) disable iff (!arst_n)
      (strobe_active && !tick) |=> strobe_active;
   endproperty
   a_high_holds: assert property (p_high_holds) else $error("strobe dropped between ticks"); // R7

   property p_strobe_line;
      @(posedge sys_clk) disable iff (!arst_n)
      (line_cfg[0].src == strobe_ctrl_pkg::SRC_STROBE && !line_cfg[0].invert)
      |=> line_out[0] == $past(strobe_active);
   endproperty
   a_strobe_line: assert property (p_strobe_line) else $error("strobe not on line"); // R1

   property p_tick_spacing;
      @(posedge sys_clk) disable iff (!arst_n)
      tick |=> !tick [*8];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent"); // R9

endmodule : camera_output_line_strobe_ctrl

// >>> sim/strobe_lamp_model.sv
// Purpose: Behavioural flash lamp wired to one camera output line.
// Assumes: The line is sampled on sys_clk; high means the lamp fires.
// Notes:   Reports the number of flashes and the width of the last one in clocks.
`timescale 1ns/100ps
module strobe_lamp_model (
   // Clock and line
   input  wire logic sys_clk,
   input  wire logic lamp_line,
   // Observations
   output int        flash_count,
   output int        last_width
);
   // ***************************************************************
   // Flash measurement
   // ***************************************************************
   // The counters are two-state and start at zero, so one process alone drives them.
   int run_len;

   // A flash is only counted once it ends, so the width is known when the count moves.
   always @(posedge sys_clk)
   begin
      if (lamp_line === 1'b1)
         run_len <= run_len + 1;
      else
      begin
         if (run_len > 0)
         begin
            flash_count <= flash_count + 1;
            last_width  <= run_len;
         end
         run_len <= 0;
      end
   end
endmodule : strobe_lamp_model

// >>> sim/camera_output_line_strobe_ctrl_tb.sv
// Purpose: Self-checking bench for the camera output line strobe control.
// Assumes: Tick shortened to 10 clocks; inputs change on the falling edge.
// Notes:   A lamp model on the isolated line measures the strobe width.
`timescale 1ns/100ps
module camera_output_line_strobe_ctrl_tb;
   // ***************************************************************
   // Signals
   // ***************************************************************
   localparam int unsigned TC = 10;
   logic                             sys_clk;
   logic                             arst_n;
   logic                             exposure_start;
   logic                             exposure_end;
   strobe_ctrl_pkg::strobe_cfg_t     strobe_cfg;
   strobe_ctrl_pkg::line_cfg_t [2:0] line_cfg;
   logic [31:0]                      user_output_value;
   logic                             strobe_active;
   logic [2:0]                       line_out;
   int                               num_errors;
   int                               samples_checked;
   int                               flash_count;
   int                               last_width;

   camera_output_line_strobe_ctrl #(.TICK_CYCLES(TC)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .exposure_start(exposure_start), .exposure_end(exposure_end), .strobe_cfg(strobe_cfg),
      .line_cfg(line_cfg), .user_output_value(user_output_value),
      .strobe_active(strobe_active), .line_out(line_out));
   strobe_lamp_model lamp (.sys_clk(sys_clk), .lamp_line(line_out[0]),
      .flash_count(flash_count), .last_width(last_width));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic set_lines(input logic src, input logic inv, input logic is_out);
      @(negedge sys_clk);
      for (int i = 0; i < 3; i++)
         line_cfg[i] = '{src: strobe_ctrl_pkg::out_src_t'(src), invert: inv, is_output: is_out};
   endtask : set_lines

   task automatic pulse(input logic use_end);
      @(negedge sys_clk);
      exposure_start = !use_end;
      exposure_end   = use_end;
      @(negedge sys_clk);
      exposure_start = 1'b0;
      exposure_end   = 1'b0;
   endtask : pulse

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic user_lines();
      logic [2:0] mask [3] = '{3'h0, 3'h1, 3'h7};
      for (int m = 0; m < 3; m++)
      begin
         set_lines(1'b1, m > 0, m == 2);
         for (int v = 0; v < 8; v++)
         begin
            user_output_value = 32'hffff_fff8 | 32'(v);
            repeat (2) @(negedge sys_clk);
            check("user_line_out", 32'(line_out), 32'(3'(v) ^ mask[m]));
         end
      end
      $display("test user_lines done");
   endtask : user_lines

   task automatic strobe_run(input logic mode, input int d, input int h);
      int base;
      int rise;
      int width;
      base = flash_count;
      set_lines(1'b0, 1'b0, 1'b1);
      strobe_cfg = '{delay_mode: strobe_ctrl_pkg::delay_mode_t'(mode),
                     delay_us: 23'(d), high_us: 23'(h)};
      pulse(!mode);
      repeat (3 * TC) @(negedge sys_clk);
      check("wrong_event_idle", 32'(strobe_active), 32'h0);
      pulse(mode);
      rise = 1;
      while (strobe_active !== 1'b1 && rise < d * TC + 4)
      begin
         @(negedge sys_clk);
         rise++;
      end
      if (h == 0)
         check("no_high_idle", 32'(strobe_active), 32'h0);
      else
      begin
         check("delay_window", 32'(rise >= d * TC && rise <= d * TC + 3), 32'h1);
         @(negedge sys_clk);
         check("strobe_lines", 32'(line_out), 32'h7);
         pulse(mode);
         width = 3;
         while (strobe_active === 1'b1 && width < h * TC + 4)
         begin
            @(negedge sys_clk);
            width++;
         end
         check("high_window", 32'(width >= h * TC && width <= h * TC + 1), 32'h1);
      end
      repeat ((d + 1) * TC + 4) @(negedge sys_clk);
      check("flash_count", 32'(flash_count), 32'(base + (h > 0)));
      if (h > 0)
         check("lamp_width", 32'(last_width >= h * TC && last_width <= h * TC + 1), 32'h1);
      $display("test strobe mode %0d delay %0d high %0d done", mode, d, h);
   endtask : strobe_run

   // ***************************************************************
   // Clock, watchdog and verdict
   // ***************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // The whole run needs well under 2000 clocks, so this limit only cuts a hang.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      complete_run();
   end

   initial
   begin
      num_errors = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      exposure_start = 1'b0;
      exposure_end = 1'b0;
      strobe_cfg = '0;
      line_cfg = '0;
      user_output_value = 32'h0;
      repeat (12) @(negedge sys_clk);
      check("reset_lines", 32'({strobe_active, line_out}), 32'h0);
      arst_n = 1'b1;
      user_lines();
      strobe_run(1'b0, 2, 3);
      strobe_run(1'b1, 3, 1);
      strobe_run(1'b0, 0, 2);
      strobe_run(1'b1, 1, 0);
      complete_run();
   end
endmodule : camera_output_line_strobe_ctrl_tb
